/* core/tfw_decoder.sv */
// Summary of operation
// - Nine-track words get zeros in bits the narrower interface lacks.
// - Bit 8 set in seven-track modes records each octal digit twice.
// - Redundant octal forces odd parity; zero digit becomes 0 111 000.
// - Reading redundant octal ORs both frame halves; 111 000 reads as zero.
// - Bit 8 clear packs two digits per frame with selected parity.
// - Seven-track bit 7 selects odd (one) or even (zero) parity.
// - Nine-track bit 7 selects phase encoding (one) or NRZI (zero).
// - NRZI/PE sampled on writes at load point, kept per transport.
// - Basic seven-track bit 6 selects 556 or 200 frames per inch.
// - Extended mode bits 6,5 give 200, 556, 800 or keep density.
// - Nine-track NRZI uses extended density codes; PE forces 1600.
// - Basic mode address word: bit 17 set, rest zero, code low.
// - Transport chosen by matching its address switch to the code.
// - Extended mode addresses in bits 4-0; zero low bits reuse last.
// - Nine-track addresses in bits 3,2; switches above 4 unreachable.
// - Duplex control only in extended seven-track and nine-track modes.
// - Non-duplex words start operations: from the controller only, or from any source in basic mode.
// - Non-duplex word from non-controller gets not-in-control interrupt.
// - Release by controller drops control after the current operation.
// - Release from a non-controller is ignored without response.
// - Duplex code in bits 17,16 (extended) or 1,0 (nine-track).
// - Modulus taken from bits 10,9 in all modes.
`default_nettype none
module tfw_decoder
  import tfw_pkg::*;
#(
  parameter int NTR     = 4,
  parameter int WORD_W  = 36,
  parameter int IFACE_W = 36
)(
  // Clock and reset.
  input  wire logic                   clk,
  input  wire logic                   resetn,
  // Static configuration.
  input  wire tfw_mode_t              mode,
  // Function word channel.
  input  wire logic                   fw_valid,
  input  wire logic                   fw_src,
  input  wire logic [FW_W-1:0]        fw_word,
  input  wire logic                   op_is_write,
  input  wire logic                   op_busy,
  // Transport pins.
  input  wire logic [NTR*SW_W-1:0]    addr_switch,
  input  wire logic [NTR-1:0]         load_point,
  input  wire logic                   tape_pe_found,
  // Frame data.
  input  wire logic                   wr_valid,
  input  wire logic [5:0]             wr_char,
  input  wire logic                   rd_valid,
  input  wire logic [6:0]             rd_frame,
  input  wire logic [WORD_W-1:0]      wr_word,
  // Decoded command.
  output logic                        cmd_start_q,
  output logic                        cmd_src_q,
  output logic                        sel_valid_q,
  output logic [$clog2(NTR)-1:0]      sel_transport_q,
  output logic                        redundant_q,
  output logic                        odd_parity_q,
  output logic                        pe_mode_q,
  output tfw_density_t                density_q,
  output logic [1:0]                  modulus_q,
  output logic [3:0]                  frames_per_word_q,
  // Status interrupt and control ownership.
  output logic                        int_valid_q,
  output logic                        int_dest_q,
  output logic                        int_in_control_q,
  output logic                        int_not_in_control_q,
  output logic                        owner_valid_q,
  output logic                        owner_q,
  // Formatted frames.
  output logic                        wr_frame_valid_q,
  output logic [6:0]                  wr_frame_q,
  output logic                        rd_char_valid_q,
  output logic [5:0]                  rd_char_q,
  output logic [WORD_W-1:0]           nine_word_q
);
  localparam int NTR_W = $clog2(NTR);
  localparam logic [WORD_W-1:0] IFACE_MASK = {WORD_W{1'b1}} >> (WORD_W - IFACE_W);

  // Picks the lowest transport whose switch equals the code.
  function automatic logic [NTR_W:0] tfw_match(input logic [5:0] code,
                                               input logic [NTR*SW_W-1:0] sw,
                                               input logic lim);
    logic [NTR_W:0] r;
    r = '0;
    for (int i = NTR - 1; i >= 0; i--)
    begin
      if (sw[i*SW_W +: SW_W] == code && (!lim || sw[i*SW_W +: SW_W] <= NINE_ADDR_MAX))
        r = {1'b1, NTR_W'(i)};
    end
    return r;
  endfunction : tfw_match

  function automatic logic tfw_par(input logic [5:0] x, input logic odd);
    return odd ? ~(^x) : ^x;
  endfunction : tfw_par

  logic [NTR*SW_W-1:0] sw_s1_q, sw_s2_q;
  logic [NTR-1:0]      lp_s1_q, lp_s2_q;
  logic                pe_s1_q, pe_s2_q;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      sw_s1_q <= '0;
      sw_s2_q <= '0;
      lp_s1_q <= '0;
      lp_s2_q <= '0;
      pe_s1_q <= 1'b0;
      pe_s2_q <= 1'b0;
    end
    else
    begin
      sw_s1_q <= addr_switch;
      sw_s2_q <= sw_s1_q;
      lp_s1_q <= load_point;
      lp_s2_q <= lp_s1_q;
      pe_s1_q <= tape_pe_found;
      pe_s2_q <= pe_s1_q;
    end
  end

  tfw_ctl_t            ctl_q, ctl_d;
  logic                owner_d, cmd_start_d, sel_valid_d, redundant_d, odd_d, pe_mode_d;
  logic                int_valid_d, int_dest_d, int_in_d, int_not_d;
  logic [NTR_W-1:0]    sel_d;
  logic [NTR-1:0]      pe_tr_q, pe_tr_d;
  tfw_density_t        density_d;
  logic [1:0]          modulus_d, dup, dcode;
  logic [3:0]          fpw_d;
  logic                duplex_en, owner_ok, accept;
  logic [NTR_W:0]      hit;

  always_comb
  begin
    ctl_d       = ctl_q;
    owner_d     = owner_q;
    cmd_start_d = 1'b0;
    sel_valid_d = sel_valid_q;
    sel_d       = sel_transport_q;
    redundant_d = redundant_q;
    odd_d       = odd_parity_q;
    pe_mode_d   = pe_mode_q;
    pe_tr_d     = pe_tr_q;
    density_d   = density_q;
    modulus_d   = modulus_q;
    fpw_d       = frames_per_word_q;
    int_valid_d = 1'b0;
    int_dest_d  = int_dest_q;
    int_in_d    = 1'b0;
    int_not_d   = 1'b0;
    hit         = '0;
    accept      = 1'b0;
    duplex_en   = (mode != MODE_BASIC7);
    dup = (mode == MODE_EXT7) ? fw_word[FW_DUP_EXT_HI:FW_DUP_EXT_LO]
                              : fw_word[FW_DUP_NINE_HI:FW_DUP_NINE_LO];
    owner_ok = !duplex_en || (ctl_q != CTL_FREE && owner_q == fw_src);
    dcode    = fw_word[FW_DEN_HI:FW_DEN_LO];
    if (ctl_q == CTL_RELEASING && !op_busy)
      ctl_d = CTL_FREE;
    if (fw_valid && mode == MODE_BASIC7 && fw_word[FW_ADDR_FLAG]
        && fw_word[FW_ADDR_ZHI:FW_ADDR_ZLO] == '0)
    begin
      hit         = tfw_match(fw_word[SW_W-1:0], sw_s2_q, 1'b0);
      sel_valid_d = hit[NTR_W];
      sel_d       = hit[NTR_W-1:0];
    end
    else if (fw_valid && (!duplex_en || dup == DUP_NONDUPLEX))
    begin
      if (owner_ok)
      begin
        if (mode == MODE_EXT7)
        begin
          if (fw_word[FW_REUSE_HI:0] != '0)
          begin
            hit = tfw_match({1'b0, fw_word[FW_EXT_ADDR_HI:0]}, sw_s2_q, 1'b0);
            sel_valid_d = hit[NTR_W];
            sel_d       = hit[NTR_W-1:0];
          end
        end
        else if (mode == MODE_NINE)
        begin
          hit = tfw_match(6'(fw_word[FW_NINE_HI:FW_NINE_LO]) + NINE_ADDR_BASE,
                          sw_s2_q, 1'b1);
          sel_valid_d = hit[NTR_W];
          sel_d       = hit[NTR_W-1:0];
        end
        accept      = sel_valid_d;
        cmd_start_d = accept;
        modulus_d   = fw_word[FW_MOD_HI:FW_MOD_LO];
        if (mode == MODE_NINE)
        begin
          redundant_d = 1'b0;
          odd_d       = 1'b1;
          fpw_d       = MOD9_BASE + 4'(modulus_d);
          if (accept && op_is_write && lp_s2_q[sel_d])
            pe_tr_d[sel_d] = fw_word[FW_PARITY];
          pe_mode_d = op_is_write ? pe_tr_d[sel_d] : pe_s2_q;
          if (fw_word[FW_PARITY])
            density_d = DEN_1600;
        end
        else
        begin
          redundant_d = fw_word[FW_OCTAL];
          odd_d       = fw_word[FW_OCTAL] | fw_word[FW_PARITY];
          pe_mode_d   = 1'b0;
          fpw_d       = (MOD7_BASE + 4'(modulus_d)) << redundant_d;
        end
        if (mode == MODE_BASIC7)
          density_d = fw_word[FW_DEN_HI] ? DEN_556 : DEN_200;
        else if (!(mode == MODE_NINE && fw_word[FW_PARITY]))
        begin
          unique case (dcode)
            DCODE_200: density_d = DEN_200;
            DCODE_556: density_d = DEN_556;
            DCODE_800: density_d = DEN_800;
            DCODE_KEEP: density_d = density_q;
          endcase
        end
      end
      else
      begin
        int_valid_d = 1'b1;
        int_dest_d  = fw_src;
        int_not_d   = 1'b1;
      end
    end
    else if (fw_valid && dup == DUP_RELEASE)
    begin
      if (ctl_q == CTL_HELD && owner_q == fw_src)
        ctl_d = op_busy ? CTL_RELEASING : CTL_FREE;
    end
    else if (fw_valid && dup == DUP_REQUEST)
    begin
      if (ctl_q == CTL_FREE || owner_q == fw_src)
      begin
        ctl_d       = CTL_HELD;
        owner_d     = fw_src;
        int_valid_d = 1'b1;
        int_dest_d  = fw_src;
        int_in_d    = 1'b1;
      end
    end
    else if (fw_valid)
    begin
      if (ctl_q != CTL_FREE && owner_q != fw_src)
      begin
        int_valid_d = 1'b1;
        int_dest_d  = owner_q;
        int_not_d   = 1'b1;
      end
      ctl_d   = CTL_HELD;
      owner_d = fw_src;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      ctl_q                <= CTL_FREE;
      owner_q              <= 1'b0;
      cmd_start_q          <= 1'b0;
      cmd_src_q            <= 1'b0;
      sel_valid_q          <= 1'b0;
      sel_transport_q      <= '0;
      redundant_q          <= 1'b0;
      odd_parity_q         <= 1'b1;
      pe_mode_q            <= 1'b0;
      pe_tr_q              <= '0;
      density_q            <= DEN_200;
      modulus_q            <= '0;
      frames_per_word_q    <= MOD7_BASE;
      int_valid_q          <= 1'b0;
      int_dest_q           <= 1'b0;
      int_in_control_q     <= 1'b0;
      int_not_in_control_q <= 1'b0;
      owner_valid_q        <= 1'b0;
    end
    else
    begin
      ctl_q                <= ctl_d;
      owner_valid_q        <= (ctl_d != CTL_FREE);
      owner_q              <= owner_d;
      cmd_start_q          <= cmd_start_d;
      cmd_src_q            <= cmd_start_d ? fw_src : cmd_src_q;
      sel_valid_q          <= sel_valid_d;
      sel_transport_q      <= sel_d;
      redundant_q          <= redundant_d;
      odd_parity_q         <= odd_d;
      pe_mode_q            <= pe_mode_d;
      pe_tr_q              <= pe_tr_d;
      density_q            <= density_d;
      modulus_q            <= modulus_d;
      frames_per_word_q    <= fpw_d;
      int_valid_q          <= int_valid_d;
      int_dest_q           <= int_dest_d;
      int_in_control_q     <= int_in_d;
      int_not_in_control_q <= int_not_d;
    end
  end

  logic [6:0]        wr_frame_d;
  logic [5:0]        rd_char_d;
  logic [2:0]        rd_digit;
  logic [WORD_W-1:0] nine_word_d;

  always_comb
  begin
    if (redundant_q)
      wr_frame_d = (wr_char[2:0] == '0) ? OCT_ZERO_FRAME
                 : {tfw_par({2{wr_char[2:0]}}, 1'b1), {2{wr_char[2:0]}}};
    else
      wr_frame_d = {tfw_par(wr_char, odd_parity_q), wr_char};
    rd_digit = ({rd_frame[5:3], rd_frame[2:0]} == OCT_ZERO_FRAME[5:0]) ? '0
             : (rd_frame[5:3] | rd_frame[2:0]);
    rd_char_d   = redundant_q ? {3'h0, rd_digit} : rd_frame[5:0];
    nine_word_d = wr_word & IFACE_MASK;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      wr_frame_valid_q <= 1'b0;
      wr_frame_q       <= '0;
      rd_char_valid_q  <= 1'b0;
      rd_char_q        <= '0;
      nine_word_q      <= '0;
    end
    else
    begin
      wr_frame_valid_q <= wr_valid;
      wr_frame_q       <= wr_frame_d;
      rd_char_valid_q  <= rd_valid;
      rd_char_q        <= rd_char_d;
      nine_word_q      <= nine_word_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  not_in_ctl_a: assert property (fw_valid && duplex_en && dup == DUP_NONDUPLEX && !owner_ok
    |=> !cmd_start_q && int_not_in_control_q && int_dest_q == $past(fw_src))
    else $error("Non-controller word was not refused.");
  start_owner_a: assert property (cmd_start_q && mode != MODE_BASIC7
    |-> $past(owner_valid_q) && $past(owner_q) == cmd_src_q)
    else $error("Operation started without control.");
  release_other_a: assert property (fw_valid && dup == DUP_RELEASE && duplex_en
    && !(owner_valid_q && owner_q == fw_src) && (op_busy || ctl_q != CTL_RELEASING)
    |=> $stable(ctl_q) && !int_valid_q)
    else $error("Release from non-controller had an effect.");
  release_busy_a: assert property (fw_valid && dup == DUP_RELEASE && duplex_en
    && ctl_q == CTL_HELD && owner_q == fw_src && op_busy |=> owner_valid_q)
    else $error("Control dropped during operation.");
  octal_zero_a: assert property (wr_valid && redundant_q && wr_char[2:0] == '0
    |=> wr_frame_q == OCT_ZERO_FRAME)
    else $error("Octal zero frame wrong.");
  frame_parity_a: assert property (wr_valid ##1 wr_frame_valid_q
    |-> (^wr_frame_q) == ($past(odd_parity_q) | $past(redundant_q)))
    else $error("Frame parity wrong.");
  read_or_a: assert property (rd_valid && redundant_q |=> rd_char_q[5:3] == '0)
    else $error("Redundant read not folded.");
  nine_fill_a: assert property ((nine_word_q & ~IFACE_MASK) == '0)
    else $error("Unsupplied bits not zero.");
  pe_density_a: assert property (fw_valid && accept && mode == MODE_NINE
    && fw_word[FW_PARITY] |=> density_q == DEN_1600)
    else $error("PE density not 1600.");
  nine_limit_a: assert property (cmd_start_q && mode == MODE_NINE
    |-> sw_s2_q[sel_transport_q*SW_W +: SW_W] <= NINE_ADDR_MAX)
    else $error("High switch selected in nine-track.");

  start_c: cover property (cmd_start_q);
  refuse_c: cover property (int_not_in_control_q);
  release_c: cover property (ctl_q == CTL_RELEASING ##[1:20] ctl_q == CTL_FREE);
endmodule : tfw_decoder
`default_nettype wire

/* core/tfw_pkg.sv */
`default_nettype none
package tfw_pkg;
  localparam int FW_W = 18;
  // Function word field positions.
  localparam int FW_DUP_EXT_HI  = 17;
  localparam int FW_DUP_EXT_LO  = 16;
  localparam int FW_DUP_NINE_HI = 1;
  localparam int FW_DUP_NINE_LO = 0;
  localparam int FW_ADDR_FLAG   = 17;
  localparam int FW_ADDR_ZHI    = 16;
  localparam int FW_ADDR_ZLO    = 6;
  localparam int FW_MOD_HI      = 10;
  localparam int FW_MOD_LO      = 9;
  localparam int FW_OCTAL       = 8;
  localparam int FW_PARITY      = 7;
  localparam int FW_DEN_HI      = 6;
  localparam int FW_DEN_LO      = 5;
  localparam int FW_EXT_ADDR_HI = 4;
  localparam int FW_REUSE_HI    = 2;
  localparam int FW_NINE_HI     = 3;
  localparam int FW_NINE_LO     = 2;
  localparam int SW_W           = 6;
  localparam logic [5:0] NINE_ADDR_BASE = 6'h01;
  localparam logic [5:0] NINE_ADDR_MAX  = 6'h04;
  // Duplex control codes.
  localparam logic [1:0] DUP_NONDUPLEX = 2'h0;
  localparam logic [1:0] DUP_RELEASE   = 2'h1;
  localparam logic [1:0] DUP_REQUEST   = 2'h2;
  localparam logic [1:0] DUP_DEMAND    = 2'h3;
  // Density codes carried in the two density bits.
  localparam logic [1:0] DCODE_200  = 2'h0;
  localparam logic [1:0] DCODE_556  = 2'h2;
  localparam logic [1:0] DCODE_800  = 2'h1;
  localparam logic [1:0] DCODE_KEEP = 2'h3;
  // Modulus bases and the redundant octal zero frame.
  localparam logic [3:0] MOD7_BASE = 4'h3;
  localparam logic [3:0] MOD9_BASE = 4'h2;
  localparam logic [6:0] OCT_ZERO_FRAME = 7'h38;
  localparam logic [2:0] OCT_ZERO_HALVES = 3'h7;
  typedef enum logic [2:0] {
    MODE_BASIC7 = 3'h1,
    MODE_EXT7   = 3'h2,
    MODE_NINE   = 3'h4
  } tfw_mode_t;
  typedef enum logic [1:0] {
    DEN_200  = 2'h0,
    DEN_556  = 2'h1,
    DEN_800  = 2'h2,
    DEN_1600 = 2'h3
  } tfw_density_t;
  typedef enum logic [2:0] {
    CTL_FREE      = 3'h1,
    CTL_HELD      = 3'h2,
    CTL_RELEASING = 3'h4
  } tfw_ctl_t;
endpackage : tfw_pkg
`default_nettype wire

/* sim/tfw_host.sv */
`default_nettype none
module tfw_host
  import tfw_pkg::*;
(
  // Clock.
  input  wire logic            clk,
  // Function word channel.
  output logic                 fw_valid,
  output logic                 fw_src,
  output logic [FW_W-1:0]      fw_word,
  output logic                 op_is_write
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    fw_valid    = 1'b0;
    fw_src      = 1'b0;
    fw_word     = '0;
    op_is_write = 1'b0;
  end

  // Sends one function word for one cycle, then drives the inverse so stale data never matches.
  // The caller places the duplex code in its field and a transport address in words that need one.
  task automatic send(input logic src, input logic [FW_W-1:0] word, input logic wr);
    @(posedge clk);
    fw_valid    <= 1'b1;
    fw_src      <= src;
    fw_word     <= word;
    op_is_write <= wr;
    @(posedge clk);
    fw_valid    <= 1'b0;
    fw_src      <= ~src;
    fw_word     <= ~word;
    op_is_write <= ~wr;
  endtask : send
endmodule : tfw_host
`default_nettype wire

/* sim/tb_top.sv */
`default_nettype none
module tb_top import tfw_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  // Clock, reset and configuration.
  logic             clk;
  logic             resetn;
  tfw_mode_t        mode;
  // Stimulus.
  logic             fw_valid, fw_src, op_is_write, op_busy;
  logic [FW_W-1:0]  fw_word;
  logic [23:0]      addr_switch;
  logic [3:0]       load_point;
  logic             tape_pe_found, wr_valid, rd_valid;
  logic [5:0]       wr_char;
  logic [6:0]       rd_frame;
  logic [35:0]      wr_word;
  // Observed outputs.
  logic             cmd_start_q, cmd_src_q, sel_valid_q, redundant_q, odd_parity_q, pe_mode_q;
  logic [1:0]       sel_transport_q, modulus_q;
  tfw_density_t     density_q;
  logic [3:0]       frames_per_word_q;
  logic             int_valid_q, int_dest_q, int_in_control_q, int_not_in_control_q;
  logic             owner_valid_q, owner_q, wr_frame_valid_q, rd_char_valid_q;
  logic [6:0]       wr_frame_q;
  logic [5:0]       rd_char_q;
  logic [35:0]      nine_word_q;
  int               failures = 0;
  int               n_tests = 0;

  always #25 clk = ~clk;

  tfw_host tfw_host_i (.clk(clk), .fw_valid(fw_valid), .fw_src(fw_src), .fw_word(fw_word),
    .op_is_write(op_is_write));

  tfw_decoder #(.NTR(4), .WORD_W(36), .IFACE_W(18)) tfw_decoder_i (
    .clk(clk), .resetn(resetn), .mode(mode), .fw_valid(fw_valid), .fw_src(fw_src),
    .fw_word(fw_word), .op_is_write(op_is_write), .op_busy(op_busy),
    .addr_switch(addr_switch), .load_point(load_point), .tape_pe_found(tape_pe_found),
    .wr_valid(wr_valid), .wr_char(wr_char), .rd_valid(rd_valid), .rd_frame(rd_frame),
    .wr_word(wr_word), .cmd_start_q(cmd_start_q), .cmd_src_q(cmd_src_q),
    .sel_valid_q(sel_valid_q), .sel_transport_q(sel_transport_q), .redundant_q(redundant_q),
    .odd_parity_q(odd_parity_q), .pe_mode_q(pe_mode_q), .density_q(density_q),
    .modulus_q(modulus_q), .frames_per_word_q(frames_per_word_q), .int_valid_q(int_valid_q),
    .int_dest_q(int_dest_q), .int_in_control_q(int_in_control_q),
    .int_not_in_control_q(int_not_in_control_q), .owner_valid_q(owner_valid_q),
    .owner_q(owner_q), .wr_frame_valid_q(wr_frame_valid_q), .wr_frame_q(wr_frame_q),
    .rd_char_valid_q(rd_char_valid_q), .rd_char_q(rd_char_q), .nine_word_q(nine_word_q));

  task automatic finish_test;
    $display("comparisons=%0d mismatches=%0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk

  // Checks the start pulse, the interrupt pulse and the not-in-control flag.
  task automatic ev(input logic s, input logic iv, input logic nic);
    chk(cmd_start_q, s);
    chk(int_valid_q, iv);
    chk(int_not_in_control_q, nic);
  endtask : ev

  // Checks the recording format of the last accepted word.
  task automatic fmt(input logic red, input logic odd, input tfw_density_t den,
                     input logic [3:0] fpw);
    chk(redundant_q, red);
    chk(odd_parity_q, odd);
    chk(density_q, den);
    chk(frames_per_word_q, fpw);
  endtask : fmt

  task automatic fw(input logic src, input logic [FW_W-1:0] word, input logic wr);
    tfw_host_i.send(src, word, wr);
    @(negedge clk);
  endtask : fw

  task automatic wr_fr(input logic [5:0] c, input logic [6:0] e);
    @(posedge clk);
    wr_valid <= 1'b1;
    wr_char  <= c;
    @(posedge clk);
    wr_valid <= 1'b0;
    @(negedge clk);
    chk(wr_frame_valid_q, 1'b1);
    chk(wr_frame_q, e);
  endtask : wr_fr

  task automatic rd_fr(input logic [6:0] f, input logic [5:0] e);
    @(posedge clk);
    rd_valid <= 1'b1;
    rd_frame <= f;
    @(posedge clk);
    rd_valid <= 1'b0;
    @(negedge clk);
    chk(rd_char_valid_q, 1'b1);
    chk(rd_char_q, e);
  endtask : rd_fr

  task automatic do_reset(input tfw_mode_t m);
    @(posedge clk);
    resetn <= 1'b0;
    mode   <= m;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : do_reset

  task automatic end_test(input string name);
    $display("test %s done, comparisons=%0d mismatches=%0d", name, n_tests, failures);
  endtask : end_test

  initial
  begin
    repeat (4000) @(posedge clk);
    failures++;
    finish_test();
  end

  initial
  begin
    clk = 1'b0;
    resetn = 1'b0;
    mode = MODE_EXT7;
    op_busy = 1'b0;
    addr_switch = {6'h04, 6'h02, 6'h09, 6'h0E};
    load_point = 4'h4;
    tape_pe_found = 1'b0;
    wr_valid = 1'b0;
    wr_char = 6'h00;
    rd_valid = 1'b0;
    rd_frame = 7'h00;
    wr_word = 36'hF_FFFF_FFFF;
    do_reset(MODE_EXT7);
    fw(1'b0, 18'h00009, 1'b1);
    ev(1'b0, 1'b1, 1'b1);
    chk(int_dest_q, 1'b0);
    fw(1'b0, 18'h20000, 1'b1);
    chk(owner_valid_q, 1'b1);
    chk(owner_q, 1'b0);
    chk(int_in_control_q, 1'b1);
    fw(1'b0, 18'h00329, 1'b1);
    ev(1'b1, 1'b0, 1'b0);
    chk(sel_transport_q, 2'h1);
    fmt(1'b1, 1'b1, DEN_800, 4'h8);
    chk(modulus_q, 2'h1);
    wr_fr(6'h00, 7'h38);
    fw(1'b0, 18'h00660, 1'b1);
    ev(1'b1, 1'b0, 1'b0);
    chk(sel_transport_q, 2'h1);
    fmt(1'b0, 1'b0, DEN_800, 4'h6);
    wr_fr(6'h07, 7'h47);
    fw(1'b1, 18'h10000, 1'b1);
    ev(1'b0, 1'b0, 1'b0);
    chk(owner_valid_q, 1'b1);
    @(posedge clk);
    op_busy <= 1'b1;
    fw(1'b0, 18'h10000, 1'b1);
    chk(owner_valid_q, 1'b1);
    @(posedge clk);
    op_busy <= 1'b0;
    @(negedge clk);
    chk(owner_valid_q, 1'b1);
    @(negedge clk);
    chk(owner_valid_q, 1'b0);
    end_test("extended");
    do_reset(MODE_BASIC7);
    fw(1'b1, 18'h2000E, 1'b0);
    ev(1'b0, 1'b0, 1'b0);
    chk(sel_valid_q, 1'b1);
    chk(sel_transport_q, 2'h0);
    fw(1'b1, 18'h000C0, 1'b0);
    chk(cmd_src_q, 1'b1);
    ev(1'b1, 1'b0, 1'b0);
    fmt(1'b0, 1'b1, DEN_556, 4'h3);
    fw(1'b0, 18'h00100, 1'b1);
    ev(1'b1, 1'b0, 1'b0);
    fmt(1'b1, 1'b1, DEN_200, 4'h6);
    wr_fr(6'h05, 7'h6D);
    rd_fr(7'h21, 6'h05);
    rd_fr(7'h38, 6'h00);
    end_test("basic");
    do_reset(MODE_NINE);
    fw(1'b1, 18'h00002, 1'b1);
    chk(owner_valid_q, 1'b1);
    chk(owner_q, 1'b1);
    fw(1'b1, 18'h00484, 1'b1);
    chk(cmd_src_q, 1'b1);
    ev(1'b1, 1'b0, 1'b0);
    chk(sel_transport_q, 2'h2);
    chk(pe_mode_q, 1'b1);
    fmt(1'b0, 1'b1, DEN_1600, 4'h4);
    @(posedge clk);
    load_point <= 4'h0;
    repeat (3) @(posedge clk);
    fw(1'b1, 18'h00044, 1'b1);
    chk(pe_mode_q, 1'b1);
    fmt(1'b0, 1'b1, DEN_556, 4'h2);
    fw(1'b1, 18'h00044, 1'b0);
    chk(pe_mode_q, 1'b0);
    fw(1'b1, 18'h00000, 1'b1);
    ev(1'b0, 1'b0, 1'b0);
    chk(sel_valid_q, 1'b0);
    fw(1'b0, 18'h00004, 1'b1);
    ev(1'b0, 1'b1, 1'b1);
    chk(int_dest_q, 1'b0);
    chk(nine_word_q, 36'h0_0003_FFFF);
    fw(1'b0, 18'h00002, 1'b1);
    ev(1'b0, 1'b0, 1'b0);
    chk(owner_q, 1'b1);
    fw(1'b0, 18'h00003, 1'b1);
    ev(1'b0, 1'b1, 1'b1);
    chk(int_dest_q, 1'b1);
    chk(owner_q, 1'b0);
    fw(1'b0, 18'h00004, 1'b1);
    ev(1'b1, 1'b0, 1'b0);
    chk(cmd_src_q, 1'b0);
    end_test("nine_track");
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
